// ===== common/jbst_pkg.sv
// Package for the boundary scan test access port: states, opcodes, sizes.
// Assumes a single TCK-clocked port and a core clock for the pin interface.
package jbst_pkg;

    // ----------------------------------------
    // Register sizes and capture values
    // ----------------------------------------
    localparam int          IR_WIDTH      = 8;
    localparam int          BSR_LENGTH    = 113;
    localparam int          ID_WIDTH      = 32;
    localparam int          TLR_EDGES     = 5;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;
    localparam logic        BYPASS_RESET  = 1'b0;
    localparam logic        ID_PRESENT    = 1'b1;

    // ----------------------------------------
    // Instruction codes (values arbitrary where not given)
    // ----------------------------------------
    localparam logic [7:0]  OP_EXTEST     = 8'h00;
    localparam logic [7:0]  OP_IDCODE     = 8'h21;
    localparam logic [7:0]  OP_SAMPLE     = 8'h05;
    localparam logic [7:0]  OP_CLAMP      = 8'h07;
    localparam logic [7:0]  OP_HIGHZ      = 8'h03;
    localparam logic [7:0]  OP_BYPASS     = 8'hFF;

    // ----------------------------------------
    // Controller states, Gray-coded along the scan paths
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h3,
        ST_CAP_DR  = 4'h2,
        ST_SH_DR   = 4'h6,
        ST_EX1_DR  = 4'h7,
        ST_PAU_DR  = 4'h5,
        ST_EX2_DR  = 4'h4,
        ST_UPD_DR  = 4'hC,
        ST_SEL_IR  = 4'hD,
        ST_CAP_IR  = 4'hF,
        ST_SH_IR   = 4'hE,
        ST_EX1_IR  = 4'hA,
        ST_PAU_IR  = 4'hB,
        ST_EX2_IR  = 4'h9,
        ST_UPD_IR  = 4'h8
    } jbst_state_t;

    // Selected data register
    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_BSR    = 2'h1,
        SEL_ID     = 2'h2
    } jbst_sel_t;

    // Pin-side control bundle
    typedef struct packed {
        logic extestOn;
        logic highzOn;
        logic clampOn;
    } jbst_pinctl_t;

endpackage : jbst_pkg

// ===== src/jbst_tap.sv
// Boundary scan test access port: controller, instruction, bypass, ID, boundary.
// Assumes TCK is the link clock; pin values come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none

module jbst_tap
    import jbst_pkg::*;
#(
    parameter int                  BSR_LEN  = BSR_LENGTH,
    // Identity fields: arbitrary neutral values
    parameter logic [3:0]          REV_CODE = 4'h0,
    parameter logic [15:0]         DEV_CODE = 16'h0001,
    parameter logic [10:0]         MFR_CODE = 11'h001
) (
    // Core clock domain
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [BSR_LEN-1:0] pinIn,
    output logic [BSR_LEN-1:0]     pinOut,
    output jbst_pinctl_t           pinCtl,
    // Test port, on the link clock
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tmsOe_n,
    input  wire logic              tdi,
    input  wire logic              tdiOe_n,
    output logic                   tdo,
    output logic                   tdoOe_n
);

    // ----------------------------------------
    // Pull-ups and power-up reset
    // ----------------------------------------
    // An undriven pin reads as high, like the weak internal pull-up
    wire tmsPin = tmsOe_n ? 1'b1 : tms;
    wire tdiPin = tdiOe_n ? 1'b1 : tdi;

    // The port has no reset pin; a power-on flag forces reset at start
    logic porDone = 1'b0;
    always_ff @(posedge tck) begin
        porDone <= 1'b1;
    end

    // ----------------------------------------
    // Controller
    // ----------------------------------------
    jbst_state_t state = ST_RESET;
    jbst_state_t next_state;

    always_comb begin
        case (state)
            ST_RESET:  next_state = tmsPin ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = tmsPin ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tmsPin ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tmsPin ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tmsPin ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tmsPin ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tmsPin ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tmsPin ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tmsPin ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tmsPin ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = tmsPin ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tmsPin ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tmsPin ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tmsPin ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tmsPin ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tmsPin ? ST_SEL_DR : ST_IDLE;
            default:   next_state = ST_RESET;
        endcase
    end

    // Inputs sampled on the rising edge
    always_ff @(posedge tck) begin
        state <= porDone ? next_state : ST_RESET;
    end

    wire inReset = (state == ST_RESET);
    wire capDr   = (state == ST_CAP_DR);
    wire shDr    = (state == ST_SH_DR);
    wire updDr   = (state == ST_UPD_DR);
    wire capIr   = (state == ST_CAP_IR);
    wire shIr    = (state == ST_SH_IR);
    wire updIr   = (state == ST_UPD_IR);

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    logic [IR_WIDTH-1:0] irShift = OP_IDCODE;
    logic [IR_WIDTH-1:0] irActive = OP_IDCODE;

    always_ff @(posedge tck) begin
        if (capIr) begin
            irShift <= {irShift[IR_WIDTH-1:2], IR_CAPTURE};
        end else if (shIr) begin
            irShift <= {tdiPin, irShift[IR_WIDTH-1:1]};
        end
    end

    always_ff @(posedge tck) begin
        if (!porDone || inReset) begin
            irActive <= OP_IDCODE;
        end else if (updIr) begin
            irActive <= irShift;
        end
    end

    // Instruction decode; unknown codes fall back to bypass
    wire isExtest = (irActive == OP_EXTEST);
    wire isSample = (irActive == OP_SAMPLE);
    wire isIdcode = (irActive == OP_IDCODE);
    wire isBypass = (irActive == OP_BYPASS);
    wire isClamp  = (irActive == OP_CLAMP);
    wire isHighz  = (irActive == OP_HIGHZ);

    jbst_sel_t selReg;
    assign selReg = (isExtest || isSample) ? SEL_BSR :
                    isIdcode               ? SEL_ID  : SEL_BYPASS;

    // ----------------------------------------
    // Pin capture crossing into TCK
    // ----------------------------------------
    logic [BSR_LEN-1:0] pinSync1;
    logic [BSR_LEN-1:0] pinSync2;
    always_ff @(posedge tck) begin
        pinSync1 <= pinIn;
        pinSync2 <= pinSync1;
    end

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    logic                bypassBit = BYPASS_RESET;
    logic [ID_WIDTH-1:0] idShift = '0;
    logic [BSR_LEN-1:0]  bsrShift = '0;
    logic [BSR_LEN-1:0]  bsrUpdate = '0;
    wire  [ID_WIDTH-1:0] idCode = {REV_CODE, DEV_CODE, MFR_CODE, ID_PRESENT};

    always_ff @(posedge tck) begin
        if (capDr && selReg == SEL_BYPASS) begin
            bypassBit <= BYPASS_RESET;
        end else if (shDr && selReg == SEL_BYPASS) begin
            bypassBit <= tdiPin;
        end
    end

    always_ff @(posedge tck) begin
        if (capDr && selReg == SEL_ID) begin
            idShift <= idCode;
        end else if (shDr && selReg == SEL_ID) begin
            idShift <= {tdiPin, idShift[ID_WIDTH-1:1]};
        end
    end

    always_ff @(posedge tck) begin
        if (capDr && selReg == SEL_BSR) begin
            bsrShift <= pinSync2;
        end else if (shDr && selReg == SEL_BSR) begin
            bsrShift <= {tdiPin, bsrShift[BSR_LEN-1:1]};
        end
    end

    // Parallel outputs move only in Update-DR; shifting leaves them still
    always_ff @(posedge tck) begin
        if (updDr && (isExtest || isSample)) begin
            bsrUpdate <= bsrShift;
        end
    end

    // ----------------------------------------
    // Serial output on the falling edge
    // ----------------------------------------
    logic serialBit;
    assign serialBit = shIr                 ? irShift[0]  :
                       (selReg == SEL_BSR)  ? bsrShift[0] :
                       (selReg == SEL_ID)   ? idShift[0]  : bypassBit;

    logic tdoQ = 1'b0;
    logic tdoEnQ = 1'b0;
    always_ff @(negedge tck) begin
        tdoQ   <= serialBit;
        tdoEnQ <= porDone && (shIr || shDr);
    end
    assign tdo     = tdoQ;
    assign tdoOe_n = !tdoEnQ;

    // ----------------------------------------
    // Pin control handed to the core domain
    // ----------------------------------------
    // Test-port reset only drops test modes; the memory path is untouched
    logic [2:0] ctlTck     = '0;
    logic       xferToggle = 1'b0;
    wire  [2:0] ctlNow     = {isExtest, isHighz, isClamp};
    wire        bsrLoad    = updDr && (isExtest || isSample);
    wire        xferReq    = bsrLoad || (ctlNow != ctlTck);

    // A toggle announces new words; they stand still while it crosses,
    // so test clock must stay slower than three core clocks
    always_ff @(posedge tck) begin
        ctlTck <= ctlNow;
        if (xferReq) begin
            xferToggle <= !xferToggle;
        end
    end

    logic [2:0] xferSync;
    wire        xferSeen = xferSync[2] ^ xferSync[1];
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            xferSync <= '0;
            pinOut   <= '0;
            pinCtl   <= '0;
        end else begin
            xferSync <= {xferSync[1:0], xferToggle};
            if (xferSeen) begin
                pinOut <= bsrUpdate;
                pinCtl <= jbst_pinctl_t'(ctlTck);
            end
        end
    end

endmodule : jbst_tap

`default_nettype wire

// ===== dv/jbst_tap_sva.sv
// Checker for the test access port: pin timing, reset and capture patterns.
// Assumes it is bound to jbst_tap and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module jbst_tap_sva
    import jbst_pkg::*;
#(
    parameter int BSR_LEN = BSR_LENGTH
) (
    // Core side
    input wire logic               core_clk,
    input wire logic               nrst,
    input wire logic [BSR_LEN-1:0] pinOut,
    input wire jbst_pinctl_t       pinCtl,
    // Test port
    input wire logic               tck,
    input wire logic               tms,
    input wire logic               tmsOe_n,
    input wire logic               tdo,
    input wire logic               tdoOe_n
);
    logic tmsEff;
    logic tckLive = 1'b0;
    logic tdoAtRise;
    logic oeAtRise;
    assign tmsEff = tms | tmsOe_n;
    // The port has no reset pin: checks on the fall wait for the first fall
    always @(negedge tck) tckLive <= 1'b1;
    always @(posedge tck) begin
        tdoAtRise <= tdo;
        oeAtRise  <= tdoOe_n;
    end
    sequence s_tlr; tmsEff [*5]; endsequence
    sequence s_shdr; s_tlr ##1 !tmsEff ##1 tmsEff ##1 !tmsEff [*2]; endsequence
    sequence s_shir; s_tlr ##1 !tmsEff ##1 tmsEff [*2] ##1 !tmsEff [*2]; endsequence
    property p_tlr; @(posedge tck) s_tlr |-> tdoOe_n; endproperty
    property p_idle; @(posedge tck) s_tlr ##1 !tmsEff [*3] |-> tdoOe_n; endproperty
    property p_idcode; @(posedge tck) s_shdr |=> !tdoOe_n && tdo == ID_PRESENT; endproperty
    property p_exit; @(posedge tck) s_shdr ##1 tmsEff |=> tdoOe_n; endproperty
    property p_irlo; @(posedge tck) s_shir |=> !tdoOe_n && tdo == IR_CAPTURE[0]; endproperty
    property p_irhi; @(posedge tck) s_shir ##1 !tmsEff |=> tdo == IR_CAPTURE[1]; endproperty
    property p_fall;
        @(negedge tck) disable iff (!tckLive) tdo == tdoAtRise && tdoOe_n == oeAtRise;
    endproperty
    property p_tlrpin; @(posedge tck) s_tlr ##1 tmsEff [*3] |-> pinCtl == '0; endproperty
    property p_rstout; @(posedge core_clk) !nrst |=> pinOut == '0 && pinCtl == '0; endproperty
    a_tlr: assert property (p_tlr) else $error("tdo driven in reset state");
    a_idle: assert property (p_idle) else $error("tdo driven in idle");
    a_idcode: assert property (p_idcode) else $error("id bit0 wrong");
    a_exit: assert property (p_exit) else $error("tdo driven after shift");
    a_irlo: assert property (p_irlo) else $error("ir capture bit0 wrong");
    a_irhi: assert property (p_irhi) else $error("ir capture bit1 wrong");
    a_fall: assert property (p_fall) else $error("tdo moved while tck high");
    a_tlrpin: assert property (p_tlrpin) else $error("test mode after reset");
    a_rstout: assert property (p_rstout) else $error("pin side active in reset");
endmodule : jbst_tap_sva
bind jbst_tap jbst_tap_sva #(.BSR_LEN(BSR_LEN)) jbst_tap_sva_i (.core_clk(core_clk),
    .nrst(nrst), .pinOut(pinOut), .pinCtl(pinCtl), .tck(tck), .tms(tms),
    .tmsOe_n(tmsOe_n), .tdo(tdo), .tdoOe_n(tdoOe_n));
`default_nettype wire

// ===== dv/jbst_host.sv
// Model of the board tester driving the test port.
// Assumes tck stands low between frames; no memory commands are issued.
`timescale 1ns/1ps
`default_nettype none
module jbst_host (
    output logic      tck,
    output logic      tms,
    output logic      tmsOe_n,
    output logic      tdi,
    output logic      tdiOe_n,
    input wire logic  tdo,
    input wire logic  tdoOe_n
);
    // No mode loads are sent, so the mode bit stays low and no settle wait arises
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tmsOe_n = 1'b1;
        tdi = 1'b1;
        tdiOe_n = 1'b1;
    end
    // Drive while tck is low, read tdo just before the rise
    task automatic step(input logic t, input logic d, output logic [1:0] r);
        #1;
        tms = t;
        tmsOe_n = 1'b0;
        tdi = d;
        tdiOe_n = 1'b0;
        #61.5;
        r = {tdoOe_n, tdo};
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step
    // Pins released and toggling: only the pull-ups define them
    task automatic float_clk(input int n);
        tmsOe_n = 1'b1;
        tdiOe_n = 1'b1;
        repeat (n) begin
            #1;
            tms = ~tms;
            tdi = ~tdi;
            #61.5;
            tck = 1'b1;
            #62.5;
            tck = 1'b0;
        end
    endtask : float_clk
endmodule : jbst_host
`default_nettype wire

// ===== dv/jbst_tap_tb.sv
// Testbench for the test access port: id, bypass codes, boundary scan.
// Assumes jbst_host drives the port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module jbst_tap_tb;
    import jbst_pkg::*;
    // Identity values are arbitrary
    localparam logic [3:0]   REV = 4'h0;
    localparam logic [15:0]  DEV = 16'h0001;
    localparam logic [10:0]  MFR = 11'h001;
    localparam logic [31:0]  ID_EXP = {REV, DEV, MFR, ID_PRESENT};
    localparam logic [127:0] PAT_A = {4{32'hA5C3_0F96}};
    localparam logic [127:0] PAT_B = {4{32'h3C69_E1D2}};
    logic core_clk, nrst, tck, tms, tmsOe_n, tdi, tdiOe_n, tdo, tdoOe_n;
    logic [BSR_LENGTH-1:0] pinIn, pinOut;
    jbst_pinctl_t          pinCtl;
    int                    fails = 0;
    int                    n_compared = 0;
    jbst_tap #(.REV_CODE(REV), .DEV_CODE(DEV), .MFR_CODE(MFR)) jbst_tap_i (
        .core_clk(core_clk), .nrst(nrst), .pinIn(pinIn), .pinOut(pinOut),
        .pinCtl(pinCtl), .tck(tck), .tms(tms), .tmsOe_n(tmsOe_n), .tdi(tdi),
        .tdiOe_n(tdiOe_n), .tdo(tdo), .tdoOe_n(tdoOe_n));
    jbst_host jbst_host_i (.tck(tck), .tms(tms), .tmsOe_n(tmsOe_n), .tdi(tdi),
        .tdiOe_n(tdiOe_n), .tdo(tdo), .tdoOe_n(tdoOe_n));
    task automatic chk(input logic [127:0] e, input logic [127:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic walk(input logic [7:0] p, input int n);
        logic [1:0] r;
        for (int i = 0; i < n; i++) jbst_host_i.step(p[i], 1'b1, r);
    endtask : walk
    task automatic go_ir(input logic [7:0] op, output logic [7:0] cap);
        logic [1:0] r;
        walk(8'h06, 5);
        for (int i = 0; i < 8; i++) begin
            jbst_host_i.step(i == 7, op[i], r);
            cap[i] = r[0];
        end
        walk(8'h01, 3);
    endtask : go_ir
    task automatic scan_dr(input int n, input logic [127:0] d, input int pz,
                           output logic [127:0] q);
        logic [1:0] r;
        q = '0;
        walk(8'h02, 4);
        for (int i = 0; i < n; i++) begin
            jbst_host_i.step(i == n - 1 || i == pz, d[i], r);
            q[i] = r[0];
            chk(1'b0, r[1]);
            if (i == pz) walk(8'h04, 4);
        end
        walk(8'h01, 2);
    endtask : scan_dr
    task automatic t_ident();
        logic [127:0] q;
        jbst_host_i.float_clk(5);
        chk(1'b1, tdoOe_n);
        walk(8'h00, 3);
        scan_dr(32, '0, 99, q);
        chk(ID_EXP, q[31:0]);
    endtask : t_ident
    task automatic t_bypass();
        logic [7:0] codes [4] = '{OP_BYPASS, OP_HIGHZ, OP_CLAMP, 8'h5A};
        logic [2:0] ctl [4] = '{3'b000, 3'b010, 3'b001, 3'b000};
        logic [7:0] cap;
        logic [127:0] q;
        jbst_host_i.float_clk(5);
        for (int k = 0; k < 4; k++) begin
            go_ir(codes[k], cap);
            chk(IR_CAPTURE, cap[1:0]);
            chk(ctl[k], pinCtl);
            scan_dr(4, 128'h000B, 99, q);
            chk({3'b011, BYPASS_RESET}, q[3:0]);
        end
    endtask : t_bypass
    task automatic t_boundary();
        logic [7:0] cap;
        logic [127:0] q;
        jbst_host_i.float_clk(5);
        @(posedge core_clk);
        #1 pinIn = PAT_A[BSR_LENGTH-1:0];
        go_ir(OP_SAMPLE, cap);
        scan_dr(BSR_LENGTH, PAT_B, 50, q);
        chk(PAT_A[BSR_LENGTH-1:0], q[BSR_LENGTH-1:0]);
        chk(PAT_B[BSR_LENGTH-1:0], pinOut);
        go_ir(OP_EXTEST, cap);
        chk(3'b100, pinCtl);
        chk(PAT_B[BSR_LENGTH-1:0], pinOut);
        scan_dr(BSR_LENGTH, PAT_A, 99, q);
        chk(PAT_A[BSR_LENGTH-1:0], pinOut);
        jbst_host_i.float_clk(8);
        chk(3'b000, pinCtl);
        scan_dr(1, '0, 99, q);
        chk(ID_PRESENT, q[0]);
    endtask : t_boundary
    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        nrst = 1'b0;
        pinIn = PAT_B[BSR_LENGTH-1:0];
        repeat (5) @(posedge core_clk);
        #1 nrst = 1'b1;
        t_ident();
        t_bypass();
        t_boundary();
        tally_and_finish();
    end
    initial begin
        #200_000;
        fails++;
        tally_and_finish();
    end
endmodule : jbst_tap_tb
`default_nettype wire
